// ### ccrg_regs.vh
`ifndef CCRG_REGS_VH
`define CCRG_REGS_VH
// ==========================================================================
// Register byte offsets.
`define CCRG_OFS_POWER_MGMT_CONTROL 4'h0
`define CCRG_OFS_SERIAL0 4'h4
`define CCRG_OFS_SERIAL1 4'h8
`define CCRG_OFS_SPI 4'hc
// ==========================================================================
// Power management control fields.
`define CCRG_MULT_LSB 0
`define CCRG_MULT_MSB 5
`define CCRG_DIV_LSB 6
`define CCRG_DIV_MSB 7
`define CCRG_INDIV_BIT 8
`define CCRG_SWSEL_BIT 9
`define CCRG_SDR_LSB 18
`define CCRG_SDR_MSB 20
`define CCRG_POWER_MGMT_CONTROL_MASK 32'h001c03ff
// ==========================================================================
// Strap codes and ratios.
`define CCRG_STRAP_6 2'h0
`define CCRG_STRAP_32 2'h1
`define CCRG_STRAP_16 2'h2
`define CCRG_RATIO_6 6'h06
`define CCRG_RATIO_16 6'h10
`define CCRG_RATIO_32 6'h20
// ==========================================================================
// Reset values and timing.
`define CCRG_SERIAL_RST 16'h0004
`define CCRG_SPI_RST 16'h0004
`define CCRG_CORE_EXTRA 2'h2
`define CCRG_READ_ZERO 32'h00000000
`endif

// ### ccrg_core_clock_and_reset_gen.v
// Behaviour
// - The clock ratio strap is captured while external reset is held and fixes the core ratio.
// - Strap code 00 gives 6:1, 01 gives 32:1, 10 gives 16:1, and 11 is reserved.
// - Software may select further ratios via the power management control register.
// - Core rate is input rate times multiplier divided by divider.
// - The input stage passes the reference directly or halves it when enabled.
// - The peripheral clock runs at half the core clock.
// - Each serial clock is the peripheral clock divided by its own divider register.
// - The SDRAM clock is the core clock divided by one more than the ratio in control bits 20 to 18.
// - The SPI clock is the peripheral clock divided by the SPI rate register.
// - Core reset stays asserted 4096 reference periods plus 2 core periods after release.
// - A missed setup window may add one reference period, giving 4097 at most.
`timescale 1ns/1ps
`include "ccrg_regs.vh"
module ccrg_core_clock_and_reset_gen #(
    parameter RST_CYCLES = 4096,
    parameter REF_DIV = 4
) (
    input wire clk,
    input wire rst_b,
    input wire ext_reset_b,
    input wire [1:0] clock_ratio_strap,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg ref_clock_en,
    output reg core_clock_en,
    output reg periph_clock_en,
    output reg [1:0] serial_clock_en,
    output reg sdram_clock_en,
    output reg spi_clock_en,
    output reg core_reset_b,
    output reg [5:0] core_ratio
);
    // ======================================================================
    // Strap capture and reset release synchroniser.
    reg [1:0] strap_q;
    reg ext_s1_q;
    reg ext_s2_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_q <= `CCRG_STRAP_6;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_reset_b;
            ext_s2_q <= ext_s1_q;
            if (!ext_reset_b) begin
                strap_q <= clock_ratio_strap;
            end
        end
    end

    function [5:0] strap_ratio;
        input [1:0] code;
        begin
            case (code)
                `CCRG_STRAP_6: strap_ratio = `CCRG_RATIO_6;
                `CCRG_STRAP_32: strap_ratio = `CCRG_RATIO_32;
                `CCRG_STRAP_16: strap_ratio = `CCRG_RATIO_16;
                default: strap_ratio = `CCRG_RATIO_6;
            endcase
        end
    endfunction

    // ======================================================================
    // Registers over Avalon-MM; one wait cycle per access.
    reg [31:0] power_mgmt_control_q;
    reg [15:0] serial_div_q [0:1];
    reg [15:0] spi_rate_q;
    reg ack_q;
    wire req = (avs_read | avs_write) & ~ack_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_mgmt_control_q <= `CCRG_READ_ZERO;
            serial_div_q[0] <= `CCRG_SERIAL_RST;
            serial_div_q[1] <= `CCRG_SERIAL_RST;
            spi_rate_q <= `CCRG_SPI_RST;
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `CCRG_READ_ZERO;
        end else begin
            ack_q <= req;
            avs_waitrequest <= ~req;
            if (req && avs_write) begin
                case (avs_address)
                    `CCRG_OFS_POWER_MGMT_CONTROL: power_mgmt_control_q <= avs_writedata & `CCRG_POWER_MGMT_CONTROL_MASK;
                    `CCRG_OFS_SERIAL0: serial_div_q[0] <= avs_writedata[15:0];
                    `CCRG_OFS_SERIAL1: serial_div_q[1] <= avs_writedata[15:0];
                    `CCRG_OFS_SPI: spi_rate_q <= avs_writedata[15:0];
                    default: ;
                endcase
            end
            if (req && avs_read) begin
                case (avs_address)
                    `CCRG_OFS_POWER_MGMT_CONTROL: avs_readdata <= power_mgmt_control_q;
                    `CCRG_OFS_SERIAL0: avs_readdata <= {16'h0000, serial_div_q[0]};
                    `CCRG_OFS_SERIAL1: avs_readdata <= {16'h0000, serial_div_q[1]};
                    `CCRG_OFS_SPI: avs_readdata <= {16'h0000, spi_rate_q};
                    default: avs_readdata <= `CCRG_READ_ZERO;
                endcase
            end
        end
    end

    // ======================================================================
    // Core clock synthesis as a fractional enable.
    // The accumulator adds the multiplier every system cycle and fires at reference length times divider.
    wire [5:0] mult = power_mgmt_control_q[`CCRG_SWSEL_BIT] ? power_mgmt_control_q[`CCRG_MULT_MSB:`CCRG_MULT_LSB]
                                               : strap_ratio(strap_q);
    wire [2:0] pdiv = power_mgmt_control_q[`CCRG_SWSEL_BIT] ? {1'b0, power_mgmt_control_q[`CCRG_DIV_MSB:`CCRG_DIV_LSB]} + 3'h1
                                               : 3'h1;
    wire indiv = power_mgmt_control_q[`CCRG_SWSEL_BIT] & power_mgmt_control_q[`CCRG_INDIV_BIT];
    reg [7:0] ref_cnt_q;
    reg [9:0] acc_q;
    reg [9:0] step;
    reg [9:0] thresh;
    always @* begin
        step = {4'h0, mult};
        thresh = {2'h0, REF_DIV[7:0]} * {7'h00, pdiv};
        if (indiv) begin
            // A halved input doubles the system cycles per core tick.
            thresh = {thresh[8:0], 1'b0};
        end
    end
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_cnt_q <= 8'h00;
            ref_clock_en <= 1'b0;
            acc_q <= 10'h000;
            core_clock_en <= 1'b0;
            core_ratio <= 6'h00;
        end else begin
            ref_clock_en <= (ref_cnt_q == REF_DIV[7:0] - 8'h01);
            ref_cnt_q <= (ref_cnt_q == REF_DIV[7:0] - 8'h01) ? 8'h00 : ref_cnt_q + 8'h01;
            core_ratio <= mult;
            // Ticks spread evenly, at most one per cycle, so the core rate cannot pass the system clock.
            if (acc_q + step >= thresh) begin
                acc_q <= acc_q + step - thresh;
                core_clock_en <= 1'b1;
            end else begin
                acc_q <= acc_q + step;
                core_clock_en <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Derived clocks from core enable.
    reg pdiv_q;
    reg [2:0] sdr_cnt_q;
    reg [15:0] ser_cnt_q [0:1];
    reg [15:0] spi_cnt_q;
    wire pclk_tick = core_clock_en & pdiv_q;
    wire [2:0] sdram_clock_ratio = power_mgmt_control_q[`CCRG_SDR_MSB:`CCRG_SDR_LSB];
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pdiv_q <= 1'b0;
            periph_clock_en <= 1'b0;
            sdr_cnt_q <= 3'h0;
            sdram_clock_en <= 1'b0;
            spi_cnt_q <= 16'h0000;
            spi_clock_en <= 1'b0;
        end else begin
            if (core_clock_en) begin
                pdiv_q <= ~pdiv_q;
            end
            periph_clock_en <= pclk_tick;
            sdram_clock_en <= 1'b0;
            if (core_clock_en) begin
                sdr_cnt_q <= (sdr_cnt_q >= sdram_clock_ratio) ? 3'h0 : sdr_cnt_q + 3'h1;
                sdram_clock_en <= (sdr_cnt_q >= sdram_clock_ratio);
            end
            spi_clock_en <= 1'b0;
            if (pclk_tick) begin
                spi_cnt_q <= (spi_cnt_q + 16'h0001 >= spi_rate_q) ? 16'h0000 : spi_cnt_q + 16'h0001;
                spi_clock_en <= (spi_cnt_q + 16'h0001 >= spi_rate_q);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ser
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ser_cnt_q[g] <= 16'h0000;
                    serial_clock_en[g] <= 1'b0;
                end else begin
                    serial_clock_en[g] <= 1'b0;
                    if (pclk_tick) begin
                        serial_clock_en[g] <= (ser_cnt_q[g] + 16'h0001 >= serial_div_q[g]);
                        ser_cnt_q[g] <= (ser_cnt_q[g] + 16'h0001 >= serial_div_q[g]) ? 16'h0000
                                                                                     : ser_cnt_q[g] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // ======================================================================
    // Core reset release: reference count then two core edges.
    localparam ST_HOLD = 3'b001;
    localparam ST_COUNT = 3'b010;
    localparam ST_RUN = 3'b100;
    reg [2:0] st_q;
    reg [12:0] rcnt_q;
    reg [1:0] ccnt_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_HOLD;
            rcnt_q <= 13'h0000;
            ccnt_q <= 2'h0;
            core_reset_b <= 1'b0;
        end else if (!ext_s2_q) begin
            st_q <= ST_HOLD;
            rcnt_q <= 13'h0000;
            ccnt_q <= 2'h0;
            core_reset_b <= 1'b0;
        end else begin
            case (st_q)
                ST_HOLD: begin
                    st_q <= ST_COUNT;
                end
                ST_COUNT: begin
                    if (rcnt_q < RST_CYCLES[12:0]) begin
                        if (ref_clock_en) begin
                            rcnt_q <= rcnt_q + 13'h0001;
                        end
                    end else if (core_clock_en) begin
                        ccnt_q <= ccnt_q + 2'h1;
                        if (ccnt_q + 2'h1 == `CCRG_CORE_EXTRA) begin
                            st_q <= ST_RUN;
                            core_reset_b <= 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    core_reset_b <= 1'b1;
                end
                default: begin
                    st_q <= ST_HOLD;
                end
            endcase
        end
    end
endmodule

// ### ccrg_properties.sv
`timescale 1ns/1ps
module ccrg_properties #(
    parameter RST_CYCLES = 4096,
    parameter REF_DIV = 4
) (
    input wire clk,
    input wire rst_b,
    input wire ext_reset_b,
    input wire [1:0] clock_ratio_strap,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire ref_clock_en,
    input wire core_clock_en,
    input wire periph_clock_en,
    input wire core_reset_b,
    input wire [5:0] core_ratio
);
    reg [15:0] refs_q;
    reg [15:0] gap_q;
    reg [2:0] cores_q;
    reg ref_seen_q;
    reg per_seen_q;
    wire [5:0] ratio_exp = clock_ratio_strap == 2'h0 ? 6'h06 : clock_ratio_strap == 2'h1 ? 6'h20 : 6'h10;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refs_q <= 16'h0000;
            gap_q <= 16'h0000;
            cores_q <= 3'h0;
            ref_seen_q <= 1'b0;
            per_seen_q <= 1'b0;
        end else begin
            refs_q <= ext_reset_b ? refs_q + {15'h0000, ref_clock_en} : 16'h0000;
            gap_q <= ref_clock_en ? 16'h0000 : gap_q + 16'h0001;
            cores_q <= periph_clock_en ? {2'h0, core_clock_en} : cores_q + {2'h0, core_clock_en};
            ref_seen_q <= ref_seen_q | ref_clock_en;
            per_seen_q <= core_reset_b & (per_seen_q | periph_clock_en);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence fresh_req;
        (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest);
    endsequence
    sequence ext_held;
        !ext_reset_b [*4];
    endsequence
    answer_time_a: assert property (fresh_req |=> !avs_waitrequest)
        else $error("late answer");
    wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("stray answer");
    ref_period_a: assert property (ref_clock_en && ref_seen_q |-> gap_q == REF_DIV - 1)
        else $error("reference spacing");
    periph_half_a: assert property (periph_clock_en && per_seen_q |-> cores_q == 3'h2)
        else $error("peripheral spacing");
    reset_hold_a: assert property (ext_held |-> !core_reset_b)
        else $error("early core release");
    reset_len_a: assert property ($rose(core_reset_b) |-> refs_q >= RST_CYCLES && refs_q <= RST_CYCLES + 3)
        else $error("core reset delay");
    strap_ratio_a: assert property ($rose(core_reset_b) && clock_ratio_strap != 2'h3 |-> core_ratio == ratio_exp)
        else $error("strap ratio");
endmodule

// ### ccrg_ref_supervisor.sv
`timescale 1ns/1ps
module ccrg_ref_supervisor #(
    parameter REF_DIV = 4,
    parameter HOLD_REFS = 8
) (
    input wire clk,
    output reg ext_reset_b,
    output reg [1:0] clock_ratio_strap
);
    initial begin
        ext_reset_b = 1'b0;
        clock_ratio_strap = 2'h0;
    end
    task reset_with(input [1:0] code);
        begin
            @(posedge clk);
            ext_reset_b <= 1'b0;
            clock_ratio_strap <= code;
            repeat (HOLD_REFS * REF_DIV) @(posedge clk);
            ext_reset_b <= 1'b1;
        end
    endtask
endmodule

// ### ccrg_core_clock_and_reset_gen_test.sv
`timescale 1ns/1ps
`include "ccrg_regs.vh"
module ccrg_core_clock_and_reset_gen_test;
    localparam RC = 16;
    localparam RD = 32;
    reg clk, rst_b, avs_read, avs_write;
    reg [3:0] avs_address;
    reg [31:0] avs_writedata, rd, w;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, ext_reset_b, ref_clock_en, core_clock_en, periph_clock_en;
    wire sdram_clock_en, spi_clock_en, core_reset_b;
    wire [1:0] serial_clock_en, clock_ratio_strap;
    wire [5:0] core_ratio;
    wire [6:0] ev = {ref_clock_en, spi_clock_en, sdram_clock_en, serial_clock_en, periph_clock_en, core_clock_en};
    integer error_cnt, total_checks, seed, i, k, n, m, d, sd;
    integer cnt [0:6];
    integer sv [0:3];
    ccrg_core_clock_and_reset_gen #(.RST_CYCLES(RC), .REF_DIV(RD)) uut (.*);
    ccrg_ref_supervisor #(.REF_DIV(RD), .HOLD_REFS(8)) sup (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task wrap_up;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    task give_up;
        begin
            error_cnt = error_cnt + 1;
            wrap_up;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Counts may be off by one tick, as the window starts at any phase.
    task chk_rate(input integer got, input integer num, input integer den);
        begin
            total_checks = total_checks + 1;
            if (got * den < num - den || got * den > num + den) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h exp %h", $time, got, num / den);
            end
        end
    endtask
    task bus(input wr, input [3:0] a, input [31:0] wd);
        begin
            avs_read <= !wr;
            avs_write <= wr;
            avs_address <= a;
            avs_writedata <= wd;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (avs_waitrequest !== 1'b0 && n < 64);
            if (n >= 64) give_up;
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rates(input integer mul, input integer den, input integer sdram_clock_ratio);
        begin
            for (i = 0; i < 7; i = i + 1) cnt[i] = 0;
            repeat (64 * RD) begin
                @(posedge clk);
                for (i = 0; i < 7; i = i + 1) cnt[i] = cnt[i] + ev[i];
            end
            chk_rate(cnt[6], 64, 1);
            chk_rate(cnt[0], 64 * mul, den);
            chk_rate(cnt[1], 64 * mul, den * 2);
            chk_rate(cnt[2], 64 * mul, den * 2 * sv[1]);
            chk_rate(cnt[3], 64 * mul, den * 2 * sv[2]);
            chk_rate(cnt[4], 64 * mul, den * (sdram_clock_ratio + 1));
            chk_rate(cnt[5], 64 * mul, den * 2 * sv[3]);
        end
    endtask
    initial begin
        seed = 98439;
        error_cnt = 0;
        total_checks = 0;
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h00000000;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        bus(1'b1, 4'h1, 32'hffffffff);
        for (k = 0; k < 4; k = k + 1) begin
            bus(1'b0, 4'(k * 4), 32'h00000000);
            chk(rd, k == 0 ? 32'h00000000 : {16'h0000, k == 3 ? `CCRG_SPI_RST : `CCRG_SERIAL_RST});
            sv[k] = 4;
        end
        bus(1'b0, 4'h1, 32'h00000000);
        chk(rd, `CCRG_READ_ZERO);
        for (k = 0; k < 3; k = k + 1) begin
            bus(1'b1, `CCRG_OFS_POWER_MGMT_CONTROL, 32'h00000000);
            sup.reset_with(2'(k));
            n = 0;
            while (core_reset_b !== 1'b1 && n < 4 * RC * RD) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 4 * RC * RD) give_up;
            chk_rate(n / RD, RC, 1);
            d = k == 0 ? 6 : k == 1 ? 32 : 16;
            chk({26'h0, core_ratio}, d);
            rates(d, 1, 0);
        end
        bus(1'b1, `CCRG_OFS_POWER_MGMT_CONTROL, 32'hffffffff);
        bus(1'b0, `CCRG_OFS_POWER_MGMT_CONTROL, 32'h00000000);
        chk(rd, `CCRG_POWER_MGMT_CONTROL_MASK);
        for (k = 0; k < 4; k = k + 1) begin
            m = ($random(seed) & 31) + 1;
            d = $random(seed) & 7;
            sd = $random(seed) & 7;
            for (i = 1; i < 4; i = i + 1) begin
                sv[i] = ($random(seed) & 7) + 1;
                bus(1'b1, 4'(i * 4), sv[i]);
            end
            w = (sd << 18) | 32'h00000200 | (d << 6) | m;
            bus(1'b1, `CCRG_OFS_POWER_MGMT_CONTROL, w);
            bus(1'b0, `CCRG_OFS_POWER_MGMT_CONTROL, 32'h00000000);
            chk(rd, w);
            repeat (4 * RD) @(posedge clk);
            rates(m, ((d & 3) + 1) * ((d >> 2) + 1), sd);
        end
        wrap_up;
    end
endmodule
bind ccrg_core_clock_and_reset_gen ccrg_properties #(.RST_CYCLES(RST_CYCLES), .REF_DIV(REF_DIV)) chk_i (.*);
